// ### hdl/target_view_consts.svh
`ifndef TARGET_VIEW_CONSTS_SVH
`define TARGET_VIEW_CONSTS_SVH

// ==========================================================================
// Register offsets.
`define REG_CMD 4'h0
`define REG_CTRL 4'h1
`define REG_STATUS 4'h2
`define REG_LEDS 4'h3
`define REG_TIMEOUT 4'h4
`define REG_AUTOPORT 4'h5

// ==========================================================================
// Field positions.
`define CMD_LEVEL_LSB 0
`define CMD_LEVEL_MSB 3
`define CMD_HAS_LEVEL_BIT 4
`define CMD_COUNT_LSB 8
`define CMD_COUNT_MSB 15
`define CTRL_REMOTE_RESET_BIT 0
`define CTRL_ERR_CLEAR_BIT 1

// ==========================================================================
// Reset values and limits.
`define VIEW_LEVEL_MAX 4'h8
`define VIEW_LEVEL_DEFAULT 4'h0
`define TIMEOUT_FIRST_RST 8'h0F
`define TIMEOUT_SECOND_RST 8'h00
`define AUTOPORT_RST 2'h1
`define ROWS_PER_HEADING 8

// ==========================================================================
// Timing.
`define CLK_FREQ_HZ 50000000
`define LAMP_TEST_MS 1000
`define LAMP_TEST_CYCLES (`CLK_FREQ_HZ / 1000 * `LAMP_TEST_MS)

`endif

// ### hdl/target_view_pkg.sv
package target_view_pkg;

	typedef logic [3:0] view_level_t;
	typedef logic [7:0] led_row_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HEAD = 2'b01,
		ST_ROW = 2'b10
	} seq_state_t;

endpackage

// ### hdl/view_row_if.sv
`timescale 1ns/100ps
`default_nettype none

interface view_row_if;
	logic start;
	logic [7:0] count;
	logic [7:0] row;
	logic ready;
	logic busy;
	logic valid;
	logic heading;
	logic [7:0] data;
	logic lamp_start;
	logic lamp_active;

	modport ctl(output start, output count, output row, output ready, output lamp_start,
		input busy, input valid, input heading, input data, input lamp_active);
	modport seq(input start, input count, input row, input ready,
		output busy, output valid, output heading, output data);
	modport lamp(input lamp_start, output lamp_active);
endinterface

`default_nettype wire

// ### hdl/readout_sequencer.sv
`include "target_view_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module readout_sequencer import target_view_pkg::*; (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Link to the selector.
	view_row_if.seq vif
);

	seq_state_t state_q;
	logic [7:0] left_q;
	logic [2:0] idx_q;
	logic valid_q;
	logic heading_q;
	logic [7:0] data_q;

	// ==========================================================================
	// Heading beat, then rows, with a new heading after every eighth row unless that row is the last.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			left_q <= 8'h00;
			idx_q <= 3'h0;
			valid_q <= 1'b0;
			heading_q <= 1'b0;
			data_q <= 8'h00;
		end else if (vif.start) begin
			state_q <= ST_HEAD;
			left_q <= vif.count;
			idx_q <= 3'h0;
			valid_q <= 1'b1;
			heading_q <= 1'b1;
			data_q <= 8'h00;
		end else begin
			case (state_q)
				ST_HEAD: begin
					if (vif.ready) begin
						state_q <= ST_ROW;
						heading_q <= 1'b0;
						data_q <= vif.row;
					end
				end
				ST_ROW: begin
					if (vif.ready) begin
						left_q <= left_q - 8'h01;
						idx_q <= idx_q + 3'h1;
						if (left_q == 8'h01) begin
							state_q <= ST_IDLE;
							valid_q <= 1'b0;
						end else if (idx_q == 3'(`ROWS_PER_HEADING - 1)) begin
							state_q <= ST_HEAD;
							heading_q <= 1'b1;
							data_q <= 8'h00;
						end else begin
							data_q <= vif.row;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
					valid_q <= 1'b0;
					heading_q <= 1'b0;
				end
			endcase
		end
	end

	assign vif.busy = (state_q != ST_IDLE);
	assign vif.valid = valid_q;
	assign vif.heading = heading_q;
	assign vif.data = data_q;

	// ==========================================================================
	// Checks.
	chk_row_after_heading: assert property (@(posedge clk) disable iff (rst)
		(valid_q && heading_q && vif.ready && !vif.start) |=> (valid_q && !heading_q))
		else $error("Heading was not followed by a row.");

	chk_heading_cadence: assert property (@(posedge clk) disable iff (rst)
		(state_q == ST_ROW && vif.ready && !vif.start && idx_q == 3'h7 && left_q > 8'h01)
		|=> (valid_q && heading_q))
		else $error("Heading missing after eight rows.");

	chk_count_done: assert property (@(posedge clk) disable iff (rst)
		(state_q == ST_ROW && vif.ready && !vif.start && left_q == 8'h01) |=> !valid_q)
		else $error("Readout ran past its repeat count.");

	cov_second_heading: cover property (@(posedge clk) disable iff (rst)
		(state_q == ST_ROW && idx_q == 3'h7 && vif.ready) ##1 heading_q);

endmodule // readout_sequencer

`default_nettype wire

// ### hdl/lamp_test_timer.sv
`timescale 1ns/100ps
`default_nettype none

module lamp_test_timer #(
	parameter int CYCLES = 50000000
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Link to the selector.
	view_row_if.lamp vif
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_q;
	logic active_q;

	// ==========================================================================
	// All-on window of CYCLES clocks, restarted by each press.
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
			active_q <= 1'b0;
		end else if (vif.lamp_start) begin
			cnt_q <= CW'(CYCLES - 1);
			active_q <= 1'b1;
		end else if (active_q) begin
			if (cnt_q == '0) begin
				active_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - CW'(1);
			end
		end
	end

	assign vif.lamp_active = active_q;

	// ==========================================================================
	// Checks.
	chk_lamp_load: assert property (@(posedge clk) disable iff (rst)
		vif.lamp_start |=> (active_q && cnt_q == CW'(CYCLES - 1)))
		else $error("Lamp test did not load its full duration.");

	chk_lamp_end: assert property (@(posedge clk) disable iff (rst)
		(active_q && cnt_q == '0 && !vif.lamp_start) |=> !active_q)
		else $error("Lamp test did not end on time.");

	cov_lamp_done: cover property (@(posedge clk) disable iff (rst) $fell(active_q));

endmodule // lamp_test_timer

`default_nettype wire

// ### hdl/target_led_view_selector.sv
// Chosen here: the plain strobed port and the register addresses.
`include "target_view_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module target_led_view_selector import target_view_pkg::*; #(
	parameter int LAMP_CYCLES = `LAMP_TEST_CYCLES
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic SRST,
	// Register port.
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output logic [15:0] RDATA,
	// Protection flags.
	input wire logic [5:0] TARGET_EVENTS,
	input wire logic ENABLED_FLAG,
	input wire logic ALARM_FLAG,
	input wire logic [47:0] ELEMENT_ROWS,
	input wire logic [5:0] CONTACT_INPUTS,
	input wire logic [6:0] OUTPUT_CONTACTS,
	// Front panel and port events.
	input wire logic TARGET_RESET_BUTTON,
	input wire logic AUTO_MSG_TIMED_OUT,
	// LEDs.
	output logic [7:0] LEDS,
	output logic LAMP_TEST_ACTIVE,
	// Readout stream.
	input wire logic READOUT_READY,
	output logic READOUT_VALID,
	output logic READOUT_HEADING,
	output logic [7:0] READOUT_DATA
);

	view_row_if vif();

	view_level_t view_q;
	logic [5:0] latch_q;
	logic [7:0] port_idle_timeout_first_q;
	logic [7:0] port_idle_timeout_second_q;
	logic [1:0] auto_port_q;
	logic cmd_err_q;
	led_row_t leds_q;
	logic [15:0] rdata_q;
	led_row_t row_sel;

	// ==========================================================================
	// Command decode.
	logic wr_cmd;
	logic wr_ctrl;
	view_level_t cmd_level;
	logic cmd_has_level;
	logic [7:0] cmd_count;
	logic cmd_bad;
	logic cmd_ok;
	logic remote_reset;
	logic revert_allowed;
	logic auto_revert;
	logic clear_targets;

	assign wr_cmd = WR_STB && (ADDR == `REG_CMD);
	assign wr_ctrl = WR_STB && (ADDR == `REG_CTRL);
	assign cmd_level = WDATA[`CMD_LEVEL_MSB:`CMD_LEVEL_LSB];
	assign cmd_has_level = WDATA[`CMD_HAS_LEVEL_BIT];
	assign cmd_count = WDATA[`CMD_COUNT_MSB:`CMD_COUNT_LSB];
	assign cmd_bad = wr_cmd && ((cmd_count != 8'h00 && !cmd_has_level)
		|| (cmd_has_level && cmd_level > `VIEW_LEVEL_MAX));
	assign cmd_ok = wr_cmd && !cmd_bad;
	assign remote_reset = wr_ctrl && WDATA[`CTRL_REMOTE_RESET_BIT];
	assign revert_allowed = (auto_port_q[0] && port_idle_timeout_first_q != 8'h00)
		|| (auto_port_q[1] && port_idle_timeout_second_q != 8'h00);
	assign auto_revert = AUTO_MSG_TIMED_OUT && revert_allowed;
	assign clear_targets = auto_revert || remote_reset || TARGET_RESET_BUTTON;

	// ==========================================================================
	// View level.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			view_q <= `VIEW_LEVEL_DEFAULT;
		end else if (auto_revert || remote_reset) begin
			view_q <= `VIEW_LEVEL_DEFAULT;
		end else if (cmd_ok && cmd_has_level) begin
			view_q <= cmd_level;
		end
	end

	// ==========================================================================
	// Latched targets; a new event wins over a clear in the same cycle.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			latch_q <= 6'h00;
		end else begin
			latch_q <= (clear_targets ? 6'h00 : latch_q) | TARGET_EVENTS;
		end
	end

	// ==========================================================================
	// Settings and error flag.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			port_idle_timeout_first_q <= `TIMEOUT_FIRST_RST;
			port_idle_timeout_second_q <= `TIMEOUT_SECOND_RST;
		end else if (WR_STB && ADDR == `REG_TIMEOUT) begin
			port_idle_timeout_first_q <= WDATA[7:0];
			port_idle_timeout_second_q <= WDATA[15:8];
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			auto_port_q <= `AUTOPORT_RST;
		end else if (WR_STB && ADDR == `REG_AUTOPORT) begin
			auto_port_q <= WDATA[1:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			cmd_err_q <= 1'b0;
		end else if (cmd_bad) begin
			cmd_err_q <= 1'b1;
		end else if (wr_ctrl && WDATA[`CTRL_ERR_CLEAR_BIT]) begin
			cmd_err_q <= 1'b0;
		end
	end

	// ==========================================================================
	// Row selection; LEDS bit 0 is LED 1.
	always_comb begin
		case (view_q)
			4'h0: row_sel = {ALARM_FLAG, ENABLED_FLAG, latch_q};
			4'h1: row_sel = ELEMENT_ROWS[7:0];
			4'h2: row_sel = ELEMENT_ROWS[15:8];
			4'h3: row_sel = ELEMENT_ROWS[23:16];
			4'h4: row_sel = ELEMENT_ROWS[31:24];
			4'h5: row_sel = ELEMENT_ROWS[39:32];
			4'h6: row_sel = ELEMENT_ROWS[47:40];
			4'h7: row_sel = {CONTACT_INPUTS[0], CONTACT_INPUTS[1], CONTACT_INPUTS[2],
				CONTACT_INPUTS[3], CONTACT_INPUTS[4], CONTACT_INPUTS[5], 2'b00};
			4'h8: row_sel = {OUTPUT_CONTACTS, 1'b0};
			default: row_sel = 8'h00;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			leds_q <= 8'h00;
		end else begin
			leds_q <= vif.lamp_active ? 8'hFF : row_sel;
		end
	end

	// ==========================================================================
	// Readout and lamp test hand-off.
	assign vif.start = cmd_ok || remote_reset;
	assign vif.count = (remote_reset || cmd_count == 8'h00) ? 8'h01 : cmd_count;
	assign vif.row = row_sel;
	assign vif.ready = READOUT_READY;
	assign vif.lamp_start = TARGET_RESET_BUTTON;

	readout_sequencer u_seq (
		.clk(CLK),
		.rst(SRST),
		.vif(vif.seq)
	);

	lamp_test_timer #(
		.CYCLES(LAMP_CYCLES)
	) u_lamp (
		.clk(CLK),
		.rst(SRST),
		.vif(vif.lamp)
	);

	// ==========================================================================
	// Register reads; data stand only in the cycle after the strobe.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rdata_q <= 16'h0000;
		end else if (RD_STB) begin
			case (ADDR)
				`REG_STATUS: rdata_q <= {9'h0, cmd_err_q, vif.busy, vif.lamp_active, view_q};
				`REG_LEDS: rdata_q <= {8'h00, leds_q};
				`REG_TIMEOUT: rdata_q <= {port_idle_timeout_second_q, port_idle_timeout_first_q};
				`REG_AUTOPORT: rdata_q <= {14'h0, auto_port_q};
				default: rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign RDATA = rdata_q;
	assign LEDS = leds_q;
	assign LAMP_TEST_ACTIVE = vif.lamp_active;
	assign READOUT_VALID = vif.valid;
	assign READOUT_HEADING = vif.heading;
	assign READOUT_DATA = vif.data;

	// ==========================================================================
	// Checks.
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	chk_level_range: assert property (view_q <= `VIEW_LEVEL_MAX)
		else $error("View level left its range.");

	chk_inputs_view: assert property (
		(view_q == 4'h7 && !vif.lamp_active) |=> (leds_q[2] == $past(CONTACT_INPUTS[5])
		&& leds_q[7] == $past(CONTACT_INPUTS[0]) && leds_q[1:0] == 2'b00))
		else $error("Contact input view is wrong.");

	chk_outputs_view: assert property (
		(view_q == 4'h8 && !vif.lamp_active) |=> (leds_q[1] == $past(OUTPUT_CONTACTS[0])
		&& leds_q[7] == $past(OUTPUT_CONTACTS[6]) && !leds_q[0]))
		else $error("Output contact view is wrong.");

	chk_reset_default: assert property ($past(SRST) |-> view_q == 4'h0)
		else $error("Default view not selected after reset.");

	chk_auto_revert: assert property (
		auto_revert |=> (view_q == 4'h0 && latch_q == $past(TARGET_EVENTS)))
		else $error("Timed-out port message did not revert the view.");

	chk_lamp_all_on: assert property (TARGET_RESET_BUTTON |-> ##2 leds_q == 8'hFF)
		else $error("Lamp test did not light every LED.");

	chk_revert_blocked: assert property (
		(AUTO_MSG_TIMED_OUT && !revert_allowed && !wr_cmd && !remote_reset) |=> $stable(view_q))
		else $error("View reverted with a zero timeout.");

	chk_remote_reset: assert property (
		remote_reset |=> (view_q == 4'h0 && vif.valid && vif.heading))
		else $error("Remote reset did not restore and report the default view.");

	chk_bad_level: assert property (
		(cmd_bad && !AUTO_MSG_TIMED_OUT) |=> ($stable(view_q) && cmd_err_q))
		else $error("Rejected command changed the view.");

	chk_view_update: assert property (
		(cmd_ok && cmd_has_level && !auto_revert && !remote_reset)
		|=> view_q == $past(cmd_level))
		else $error("Accepted level did not take effect.");

	chk_default_row: assert property (
		(view_q == 4'h0 && !vif.lamp_active) |=> (leds_q[7] == $past(ALARM_FLAG)
		&& leds_q[6] == $past(ENABLED_FLAG) && leds_q[5:0] == $past(latch_q)))
		else $error("Default view row is wrong.");

	chk_first_row: assert property (
		(view_q == 4'h1 && !vif.lamp_active) |=> leds_q == $past(ELEMENT_ROWS[7:0]))
		else $error("First element row view is wrong.");

	chk_sixth_row: assert property (
		(view_q == 4'h6 && !vif.lamp_active) |=> leds_q == $past(ELEMENT_ROWS[47:40]))
		else $error("Sixth element row view is wrong.");

	chk_lamp_leds: assert property (vif.lamp_active |=> leds_q == 8'hFF)
		else $error("An LED was dark during the lamp test.");

	chk_button_clear: assert property (
		TARGET_RESET_BUTTON |=> latch_q == $past(TARGET_EVENTS))
		else $error("Reset button did not clear the latched targets.");

	chk_button_view: assert property (
		(TARGET_RESET_BUTTON && !wr_cmd && !remote_reset && !auto_revert)
		|=> $stable(view_q))
		else $error("Reset button changed the view.");

	chk_latch_hold: assert property (
		!clear_targets |=> ((latch_q & $past(latch_q)) == $past(latch_q)))
		else $error("A latched target dropped without a clear.");

	chk_remote_clear: assert property (
		remote_reset |=> latch_q == $past(TARGET_EVENTS))
		else $error("Remote reset did not clear the latched targets.");

	chk_status_read: assert property (
		(RD_STB && ADDR == `REG_STATUS)
		|=> (rdata_q[3:0] == $past(view_q) && rdata_q[15:7] == 9'h0))
		else $error("Status read did not show the view level.");

	chk_read_idle: assert property (!RD_STB |=> rdata_q == 16'h0000)
		else $error("Read data stood outside its cycle.");

	cov_view_eight: cover property (cmd_ok && cmd_has_level && cmd_level == 4'h8);
	cov_auto_revert: cover property (auto_revert && view_q != 4'h0);
	cov_remote_reset: cover property (remote_reset ##1 vif.busy);

endmodule // target_led_view_selector

`default_nettype wire

// ### sim/view_sink_model.sv
`timescale 1ns/100ps
`default_nettype none

module view_sink_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Test controls.
	input wire logic slow,
	input wire logic clr,
	// Readout stream.
	output logic ready,
	input wire logic valid,
	input wire logic heading,
	input wire logic [7:0] data,
	// Tallies.
	output int n_head,
	output int n_row,
	output logic [7:0] last_row
);

	// ======================================================================
	// Sink pacing: prompt, or ready only on every other cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			ready <= 1'b0;
		end else begin
			ready <= slow ? ~ready : 1'b1;
		end
	end

	// ======================================================================
	// Tally of heading and row beats taken.
	always_ff @(posedge clk) begin
		if (rst || clr) begin
			n_head <= 0;
			n_row <= 0;
			last_row <= 8'h00;
		end else if (valid && ready) begin
			if (heading) begin
				n_head <= n_head + 1;
			end else begin
				n_row <= n_row + 1;
				last_row <= data;
			end
		end
	end

endmodule // view_sink_model

`default_nettype wire

// ### sim/target_led_view_selector_tb.sv
`timescale 1ns/100ps
`default_nettype none

module target_led_view_selector_tb import target_view_pkg::*;;
	typedef struct {view_level_t lvl; led_row_t leds;} case_row_t;
	logic CLK = 1'b0;
	logic SRST = 1'b1;
	logic [3:0] ADDR = 4'h0;
	logic [15:0] WDATA = 16'h0000;
	logic WR_STB = 1'b0;
	logic RD_STB = 1'b0;
	logic [15:0] RDATA;
	logic [5:0] TARGET_EVENTS = 6'h00;
	logic ENABLED_FLAG = 1'b1;
	logic ALARM_FLAG = 1'b0;
	logic [47:0] ELEMENT_ROWS = 48'h665544332211;
	logic [5:0] CONTACT_INPUTS = 6'h0B;
	logic [6:0] OUTPUT_CONTACTS = 7'h25;
	logic TARGET_RESET_BUTTON = 1'b0;
	logic AUTO_MSG_TIMED_OUT = 1'b0;
	logic [7:0] LEDS;
	logic LAMP_TEST_ACTIVE;
	logic READOUT_READY, READOUT_VALID, READOUT_HEADING;
	logic [7:0] READOUT_DATA, last_row;
	logic slow = 1'b0;
	logic clr = 1'b0;
	int n_head, n_row;
	int n_errors = 0;
	int num_checks = 0;
	logic [15:0] d;
	case_row_t rows [9] = '{'{4'h0, 8'h40}, '{4'h1, 8'h11}, '{4'h2, 8'h22}, '{4'h3, 8'h33},
		'{4'h4, 8'h44}, '{4'h5, 8'h55}, '{4'h6, 8'h66}, '{4'h7, 8'hD0}, '{4'h8, 8'h4A}};

	always #10 CLK = ~CLK;

	target_led_view_selector #(.LAMP_CYCLES(20)) uut (.CLK(CLK), .SRST(SRST), .ADDR(ADDR),
		.WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
		.TARGET_EVENTS(TARGET_EVENTS), .ENABLED_FLAG(ENABLED_FLAG), .ALARM_FLAG(ALARM_FLAG),
		.ELEMENT_ROWS(ELEMENT_ROWS), .CONTACT_INPUTS(CONTACT_INPUTS),
		.OUTPUT_CONTACTS(OUTPUT_CONTACTS), .TARGET_RESET_BUTTON(TARGET_RESET_BUTTON),
		.AUTO_MSG_TIMED_OUT(AUTO_MSG_TIMED_OUT), .LEDS(LEDS),
		.LAMP_TEST_ACTIVE(LAMP_TEST_ACTIVE), .READOUT_READY(READOUT_READY),
		.READOUT_VALID(READOUT_VALID), .READOUT_HEADING(READOUT_HEADING),
		.READOUT_DATA(READOUT_DATA));

	view_sink_model sink (.clk(CLK), .rst(SRST), .slow(slow), .clr(clr), .ready(READOUT_READY),
		.valid(READOUT_VALID), .heading(READOUT_HEADING), .data(READOUT_DATA),
		.n_head(n_head), .n_row(n_row), .last_row(last_row));

	// ======================================================================
	// Bus, compare and closing tasks.
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= v;
		WR_STB <= 1'b1;
		@(posedge CLK);
		WR_STB <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge CLK);
		ADDR <= a;
		RD_STB <= 1'b1;
		@(posedge CLK);
		RD_STB <= 1'b0;
		#1 v = RDATA;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic settle();
		repeat (3) @(posedge CLK);
		#1;
	endtask

	task automatic clear_tally();
		@(posedge CLK);
		clr <= 1'b1;
		@(posedge CLK);
		clr <= 1'b0;
	endtask

	task automatic pulse_events(input logic [5:0] e);
		@(posedge CLK);
		TARGET_EVENTS <= e;
		@(posedge CLK);
		TARGET_EVENTS <= 6'h00;
		settle();
	endtask

	task automatic pulse_auto();
		@(posedge CLK);
		AUTO_MSG_TIMED_OUT <= 1'b1;
		@(posedge CLK);
		AUTO_MSG_TIMED_OUT <= 1'b0;
		settle();
	endtask

	task automatic drain();
		int k;
		for (k = 0; k < 200; k++) begin
			rd(4'h2, d);
			if (d[5] === 1'b0 && READOUT_VALID === 1'b0) break;
		end
		chk("readout done", 16'h0000, {14'h0, READOUT_VALID, d[5]});
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		n_errors++;
		test_done();
	end

	// ======================================================================
	// Main sequence.
	initial begin
		repeat (2) @(posedge CLK);
		SRST <= 1'b0;
		settle();
		chk("leds reset", 16'h0040, {8'h00, LEDS});
		rd(4'h2, d);
		chk("status reset", 16'h0000, d);
		rd(4'h4, d);
		chk("timeout reset", 16'h000F, d);
		rd(4'h5, d);
		chk("autoport reset", 16'h0001, d);
		rd(4'h7, d);
		chk("unmapped", 16'h0000, d);
		foreach (rows[i]) begin
			clear_tally();
			wr(4'h0, {11'h000, 1'b1, rows[i].lvl});
			settle();
			chk("leds view", {8'h00, rows[i].leds}, {8'h00, LEDS});
			rd(4'h2, d);
			chk("view level", {12'h000, rows[i].lvl}, d & 16'h000F);
			rd(4'h3, d);
			chk("leds register", {8'h00, rows[i].leds}, d);
			drain();
			chk("readout row", {8'h00, rows[i].leds}, {8'h00, last_row});
			chk("row beats", 16'h0001, 16'(n_row));
			chk("heading beats", 16'h0001, 16'(n_head));
		end
		clear_tally();
		wr(4'h0, 16'h0000);
		drain();
		chk("report only", 16'h004A, {8'h00, last_row});
		wr(4'h0, 16'h0019);
		rd(4'h2, d);
		chk("bad level", 16'h0048, d & 16'h004F);
		wr(4'h1, 16'h0002);
		wr(4'h0, 16'h0500);
		rd(4'h2, d);
		chk("count alone", 16'h0048, d & 16'h004F);
		wr(4'h1, 16'h0002);
		rd(4'h2, d);
		chk("error cleared", 16'h0008, d & 16'h004F);
		clear_tally();
		slow <= 1'b1;
		wr(4'h0, 16'h0A13);
		drain();
		chk("headings", 16'h0002, 16'(n_head));
		chk("rows", 16'h000A, 16'(n_row));
		chk("repeat row", 16'h0033, {8'h00, last_row});
		clear_tally();
		slow <= 1'b0;
		wr(4'h0, 16'h0813);
		drain();
		chk("headings eight", 16'h0001, 16'(n_head));
		chk("rows eight", 16'h0008, 16'(n_row));
		wr(4'h0, 16'h0010);
		drain();
		pulse_events(6'h3F);
		chk("latched", 16'h007F, {8'h00, LEDS});
		@(posedge CLK);
		TARGET_RESET_BUTTON <= 1'b1;
		@(posedge CLK);
		TARGET_RESET_BUTTON <= 1'b0;
		#1 chk("lamp on", 16'h0001, {15'h0000, LAMP_TEST_ACTIVE});
		@(posedge CLK);
		#1 chk("lamp leds", 16'h00FF, {8'h00, LEDS});
		repeat (18) @(posedge CLK);
		#1 chk("lamp held", 16'h0001, {15'h0000, LAMP_TEST_ACTIVE});
		@(posedge CLK);
		#1 chk("lamp off", 16'h0000, {15'h0000, LAMP_TEST_ACTIVE});
		@(posedge CLK);
		#1 chk("after lamp", 16'h0040, {8'h00, LEDS});
		pulse_events(6'h01);
		wr(4'h0, 16'h0015);
		drain();
		chk("view five", 16'h0055, {8'h00, LEDS});
		pulse_auto();
		chk("auto revert", 16'h0040, {8'h00, LEDS});
		wr(4'h4, 16'h0000);
		rd(4'h4, d);
		chk("timeout write", 16'h0000, d);
		wr(4'h0, 16'h0015);
		drain();
		pulse_auto();
		chk("no revert", 16'h0055, {8'h00, LEDS});
		wr(4'h4, 16'h0A00);
		pulse_auto();
		chk("first port zero", 16'h0055, {8'h00, LEDS});
		wr(4'h5, 16'h0002);
		rd(4'h5, d);
		chk("autoport write", 16'h0002, d);
		pulse_auto();
		chk("second port revert", 16'h0040, {8'h00, LEDS});
		wr(4'h0, 16'h0015);
		pulse_events(6'h02);
		clear_tally();
		wr(4'h1, 16'h0001);
		settle();
		chk("remote reset", 16'h0040, {8'h00, LEDS});
		drain();
		chk("remote view", 16'h0000, d & 16'h000F);
		chk("remote row", 16'h0040, {8'h00, last_row});
		chk("remote beats", 16'h0001, 16'(n_row));
		wr(4'h0, 16'h0A15);
		@(posedge CLK);
		SRST <= 1'b1;
		repeat (2) @(posedge CLK);
		SRST <= 1'b0;
		@(posedge CLK);
		#1 chk("leds mid reset", 16'h0040, {8'h00, LEDS});
		chk("stream mid reset", 16'h0000, {15'h0000, READOUT_VALID});
		rd(4'h2, d);
		chk("status mid reset", 16'h0000, d);
		rd(4'h5, d);
		chk("autoport mid reset", 16'h0001, d);
		@(posedge CLK);
		ALARM_FLAG <= 1'b1;
		ENABLED_FLAG <= 1'b0;
		settle();
		chk("alarm view", 16'h0080, {8'h00, LEDS});
		test_done();
	end

endmodule // target_led_view_selector_tb

`default_nettype wire
